// [qucfg_defs.svh]
// Offsets, field positions, reset values and timing counts of the device configuration block
`ifndef QUCFG_DEFS_SVH
`define QUCFG_DEFS_SVH

`define QUCFG_ADDR_INT_SUMMARY   8'h80
`define QUCFG_ADDR_INT_CODE_LOW  8'h81
`define QUCFG_ADDR_INT_CODE_HIGH 8'h82
`define QUCFG_ADDR_INT_SPARE     8'h83
`define QUCFG_ADDR_TIMER_CONTROL 8'h84
`define QUCFG_ADDR_TIMER_SPARE   8'h85
`define QUCFG_ADDR_PRESET_LOW    8'h86
`define QUCFG_ADDR_PRESET_HIGH   8'h87
`define QUCFG_ADDR_SAMPLING      8'h88
`define QUCFG_ADDR_SPARE_A       8'h89
`define QUCFG_ADDR_SOFT_RESET    8'h8A
`define QUCFG_ADDR_SLEEP         8'h8B
`define QUCFG_ADDR_REVISION      8'h8C
`define QUCFG_ADDR_PART_ID       8'h8D
`define QUCFG_ADDR_BROADCAST     8'h8E

`define QUCFG_TCTL_INT_EN_BIT    0
`define QUCFG_TCTL_START_BIT     1
`define QUCFG_TCTL_ONESHOT_BIT   2
`define QUCFG_TCTL_EXT_CLK_BIT   3
`define QUCFG_BCAST_BIT          0

`define QUCFG_RESET_BYTE         8'h00
`define QUCFG_RESET_NIBBLE       4'h0
`define QUCFG_RESET_WORD         16'h0000
`define QUCFG_TIMER_CODE         3'h7
`define QUCFG_NO_CODE            3'h0

`define QUCFG_WAKE_HOLDOFF_CYCLES 6'h20
`define QUCFG_HOLDOFF_ZERO        6'h00

`endif

// [qucfg_pkg.sv]
// Types shared by the configuration block and its timer
package qucfg_pkg;

  typedef enum logic [1:0] {
    QUCFG_TMR_IDLE  = 2'h0,
    QUCFG_TMR_RUN   = 2'h1,
    QUCFG_TMR_PAUSE = 2'h3
  } qucfg_tmr_state_type;

  typedef struct packed {
    qucfg_tmr_state_type st;
    logic [15:0]         count;
    logic                start_prev;
    logic                timeout;
  } qucfg_tmr_regs_type;

  typedef struct packed {
    logic [3:0] tctl;
    logic [7:0] preset_low;
    logic [7:0] preset_high;
    logic [3:0] mode8x;
    logic [3:0] sleep_en;
    logic       bcast;
    logic [3:0] soft_rst;
    logic [3:0] asleep;
    logic [5:0] holdoff;
    logic       timer_pend;
    logic       wake_pend;
    logic       ext_prev;
    logic [7:0] rdata;
  } qucfg_regs_type;

endpackage

// [qucfg_timer.sv]
// Sixteen-bit down counter with re-trigger and single-shot operation
`timescale 1ns/1ps
`default_nettype none
`include "qucfg_defs.svh"

module qucfg_timer (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic        oneshot,
  input  wire logic [15:0] preset,
  output logic             timeout,
  output logic [15:0]      count
);

  qucfg_pkg::qucfg_tmr_regs_type state_reg;
  qucfg_pkg::qucfg_tmr_regs_type state_next;

  always_comb begin
    state_next            = state_reg;
    state_next.start_prev = start;
    state_next.timeout    = 1'b0;
    unique case (state_reg.st)
      qucfg_pkg::QUCFG_TMR_IDLE: begin
        if (start && !state_reg.start_prev) begin
          state_next.count = preset;
          state_next.st    = qucfg_pkg::QUCFG_TMR_RUN;
        end
      end
      qucfg_pkg::QUCFG_TMR_RUN: begin
        if (!start) begin
          state_next.st = qucfg_pkg::QUCFG_TMR_PAUSE;
        end else if (tick) begin
          if (state_reg.count <= 16'h0001) begin
            state_next.timeout = 1'b1;
            if (oneshot) begin
              state_next.count = `QUCFG_RESET_WORD;
              state_next.st    = qucfg_pkg::QUCFG_TMR_IDLE;
            end else begin
              state_next.count = preset;
            end
          end else begin
            state_next.count = state_reg.count - 16'h0001;
          end
        end
      end
      qucfg_pkg::QUCFG_TMR_PAUSE: begin
        if (start) begin
          state_next.st = qucfg_pkg::QUCFG_TMR_RUN;
        end
      end
      default: begin
        state_next.st = qucfg_pkg::QUCFG_TMR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign timeout = state_reg.timeout;
  assign count   = state_reg.count;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_TMR_RELOAD: assert property ((state_reg.st == qucfg_pkg::QUCFG_TMR_RUN) && start && tick && !oneshot
    && (state_reg.count <= 16'h0001) |=> timeout && (count == $past(preset)))
    else $error("re-trigger reload missing");
  AST_TMR_ONESHOT: assert property (timeout && $past(oneshot) |-> state_reg.st == qucfg_pkg::QUCFG_TMR_IDLE)
    else $error("single-shot did not stop");
  AST_TMR_PAUSE: assert property ((state_reg.st == qucfg_pkg::QUCFG_TMR_PAUSE) |=> count == $past(count))
    else $error("paused count moved");
  COV_TMR_TIMEOUT: cover property (timeout);

endmodule // qucfg_timer

`default_nettype wire

// [qucfg_config.sv]
// Device configuration registers, general-purpose timer and sleep control of the quad serial port
`timescale 1ns/1ps
`default_nettype none
`include "qucfg_defs.svh"

// Overview of operation
// - Sixteen-bit down counter signals time-out
// - Control bit 3 picks clock source
// - Control bit 2 picks single-shot
// - Control bit 1 starts or pauses counter
// - Bit 0 enables interrupt; read clears
// - Control upper nibble reads zero
// - Preset registers form sixteen-bit load value
// - Spare timer register reads zero
// - Enabled time-out raises shared interrupt
// - Per-channel bit picks 8X sampling
// - Self-clearing per-channel reset pulse
// - Sleep only when enabled, nothing pending
// - All four asleep stops oscillator
// - Receive byte or modem change wakes
// - Hold channels off thirty-two clocks
// - Wake interrupt, no code, summary clears
// - Fixed part identifier: series, channels
// - Fixed revision identifier
// - Broadcast bit routes writes to all
// - Spare register A reserved, zero
// - Time-out shows as channel 0 code 7
// - Wake interrupt only if all slept
module qucfg_config #(
  // Arbitrary value: upper nibble series, lower nibble four channels
  parameter logic [7:0] PART_ID  = 8'h34,
  // Arbitrary value
  parameter logic [7:0] REVISION = 8'h03
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [7:0]  bus_wdata,
  output logic [7:0]       bus_rdata,
  input  wire logic        external_timer_clock_pin,
  input  wire logic [3:0]  chan_int_pending,
  input  wire logic [11:0] chan_src_code,
  input  wire logic [3:0]  chan_wake_event,
  output logic [3:0]       sample_8x,
  output logic [3:0]       chan_soft_reset,
  output logic [3:0]       chan_asleep,
  output logic             osc_stop,
  output logic             chan_ready,
  output logic             broadcast_write,
  output logic             irq_o,
  output logic             irq_oe
);

  qucfg_pkg::qucfg_regs_type state_reg;
  qucfg_pkg::qucfg_regs_type state_next;

  logic        ext_edge;
  logic        tick;
  logic        timeout;
  logic [15:0] count;
  logic        all_asleep;
  logic        wake_start;
  logic        timer_int;
  logic [11:0] src_code;
  logic        wr_hit;
  logic        rd_hit;

  assign all_asleep = &state_reg.asleep;
  // any channel event restarts the oscillator
  assign wake_start = all_asleep && (|chan_wake_event);
  // Pin is synchronous to sys_clk, so one stage of history is enough for edges
  assign ext_edge   = external_timer_clock_pin && !state_reg.ext_prev;
  assign tick       = state_reg.tctl[`QUCFG_TCTL_EXT_CLK_BIT] ? ext_edge : !all_asleep;
  assign timer_int  = state_reg.timer_pend && state_reg.tctl[`QUCFG_TCTL_INT_EN_BIT];
  assign wr_hit     = bus_wr;
  assign rd_hit     = bus_rd;

  // time-out overrides channel 0 code only
  always_comb begin
    src_code = chan_src_code;
    if (timer_int) begin
      src_code[2:0] = `QUCFG_TIMER_CODE;
    end
    // wake interrupt carries no source code
  end

  qucfg_timer u_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tick    (tick),
    .start   (state_reg.tctl[`QUCFG_TCTL_START_BIT]),
    .oneshot (state_reg.tctl[`QUCFG_TCTL_ONESHOT_BIT]),
    .preset  ({state_reg.preset_high, state_reg.preset_low}),
    .timeout (timeout),
    .count   (count)
  );

  always_comb begin
    state_next          = state_reg;
    state_next.ext_prev = external_timer_clock_pin;
    state_next.soft_rst = `QUCFG_RESET_NIBBLE;

    if (wr_hit) begin
      unique case (bus_addr)
        `QUCFG_ADDR_TIMER_CONTROL: state_next.tctl = bus_wdata[3:0];
        `QUCFG_ADDR_PRESET_LOW:    state_next.preset_low = bus_wdata;
        `QUCFG_ADDR_PRESET_HIGH:   state_next.preset_high = bus_wdata;
        `QUCFG_ADDR_SAMPLING:      state_next.mode8x = bus_wdata[3:0];
        `QUCFG_ADDR_SOFT_RESET:    state_next.soft_rst = bus_wdata[3:0];
        `QUCFG_ADDR_SLEEP:         state_next.sleep_en = bus_wdata[3:0];
        `QUCFG_ADDR_BROADCAST:     state_next.bcast = bus_wdata[`QUCFG_BCAST_BIT];
        // Spare and read-only locations ignore writes
        default: begin
        end
      endcase
    end

    // read clears, but a fresh time-out wins
    if (rd_hit && (bus_addr == `QUCFG_ADDR_TIMER_CONTROL)) begin
      state_next.timer_pend = 1'b0;
    end
    if (timeout) begin
      state_next.timer_pend = 1'b1;
    end

    if (rd_hit && (bus_addr == `QUCFG_ADDR_INT_SUMMARY)) begin
      state_next.wake_pend = 1'b0;
    end

    // sleep only when enabled and quiet
    for (int i = 0; i < 4; i++) begin
      if (!state_reg.sleep_en[i] || chan_int_pending[i] || chan_wake_event[i]) begin
        state_next.asleep[i] = 1'b0;
      end else if (state_reg.holdoff == `QUCFG_HOLDOFF_ZERO) begin
        state_next.asleep[i] = 1'b1;
      end
    end

    if (state_reg.holdoff != `QUCFG_HOLDOFF_ZERO) begin
      state_next.holdoff = state_reg.holdoff - 6'h01;
    end

    if (wake_start) begin
      state_next.asleep  = `QUCFG_RESET_NIBBLE;
      state_next.holdoff = `QUCFG_WAKE_HOLDOFF_CYCLES;
      state_next.wake_pend = 1'b1;
    end

    if (rd_hit) begin
      unique case (bus_addr)
        `QUCFG_ADDR_INT_SUMMARY:   state_next.rdata = {4'h0, chan_int_pending};
        `QUCFG_ADDR_INT_CODE_LOW:  state_next.rdata = src_code[7:0];
        `QUCFG_ADDR_INT_CODE_HIGH: state_next.rdata = {4'h0, src_code[11:8]};
        `QUCFG_ADDR_TIMER_CONTROL: state_next.rdata = {4'h0, state_reg.tctl};
        `QUCFG_ADDR_PRESET_LOW:    state_next.rdata = state_reg.preset_low;
        `QUCFG_ADDR_PRESET_HIGH:   state_next.rdata = state_reg.preset_high;
        `QUCFG_ADDR_SAMPLING:      state_next.rdata = {4'h0, state_reg.mode8x};
        `QUCFG_ADDR_SLEEP:         state_next.rdata = {4'h0, state_reg.sleep_en};
        `QUCFG_ADDR_REVISION:      state_next.rdata = REVISION;
        `QUCFG_ADDR_PART_ID:       state_next.rdata = PART_ID;
        `QUCFG_ADDR_BROADCAST:     state_next.rdata = {7'h00, state_reg.bcast};
        // spare timer, spare A, write-only reset: zero
        default:                   state_next.rdata = `QUCFG_RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_rdata       = state_reg.rdata;
  assign sample_8x       = state_reg.mode8x;
  assign chan_soft_reset = state_reg.soft_rst;
  assign chan_asleep     = state_reg.asleep;
  assign osc_stop        = all_asleep;
  assign chan_ready      = (state_reg.holdoff == `QUCFG_HOLDOFF_ZERO);
  assign broadcast_write = state_reg.bcast;
  assign irq_o           = 1'b0;
  assign irq_oe          = timer_int || state_reg.wake_pend || (|chan_int_pending);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_TCTL_RSVD: assert property (rd_hit && (bus_addr == `QUCFG_ADDR_TIMER_CONTROL) |=> bus_rdata[7:4] == 4'h0)
    else $error("timer control upper nibble not zero");
  AST_TIMER_SPARE: assert property (rd_hit && (bus_addr == `QUCFG_ADDR_TIMER_SPARE) |=> bus_rdata == 8'h00)
    else $error("spare timer register not zero");
  AST_SPARE_A: assert property (rd_hit && (bus_addr == `QUCFG_ADDR_SPARE_A) |=> bus_rdata == 8'h00)
    else $error("spare register A not zero");
  AST_TIMER_CLR: assert property (rd_hit && (bus_addr == `QUCFG_ADDR_TIMER_CONTROL) && !timeout
    |=> !state_reg.timer_pend)
    else $error("timer interrupt not cleared by read");
  AST_TIMER_SET: assert property (timeout |=> state_reg.timer_pend)
    else $error("time-out lost");
  AST_TIMER_IRQ: assert property (timer_int |-> irq_oe && (src_code[2:0] == 3'h7))
    else $error("timer interrupt not signalled");
  AST_SELF_CLEAR: assert property ((|chan_soft_reset) && !(wr_hit && bus_addr == `QUCFG_ADDR_SOFT_RESET)
    |=> chan_soft_reset == 4'h0)
    else $error("channel reset did not clear itself");
  AST_8X: assert property (wr_hit && (bus_addr == `QUCFG_ADDR_SAMPLING) |=> sample_8x == $past(bus_wdata[3:0]))
    else $error("sampling select not updated");
  AST_SLEEP_QUIET: assert property (chan_int_pending[0] |=> !chan_asleep[0])
    else $error("channel slept with interrupt pending");
  AST_HOLDOFF: assert property (wake_start |=> !chan_ready ##31 !chan_ready ##1 chan_ready)
    else $error("wake hold-off not thirty-two cycles");
  AST_WAKE_SET: assert property (wake_start |=> state_reg.wake_pend && irq_oe && !osc_stop)
    else $error("wake interrupt missing");
  AST_WAKE_CLR: assert property (rd_hit && (bus_addr == `QUCFG_ADDR_INT_SUMMARY) && !wake_start
    |=> !state_reg.wake_pend)
    else $error("wake interrupt not cleared by summary read");

  COV_WAKE: cover property (wake_start);
  COV_TIMER_INT: cover property (timer_int ##1 rd_hit && (bus_addr == `QUCFG_ADDR_TIMER_CONTROL));
  COV_SOFT_RESET: cover property (|chan_soft_reset);
  COV_ONESHOT_DONE: cover property (state_reg.tctl[`QUCFG_TCTL_ONESHOT_BIT] && timeout ##1 (count == 16'h0000));

endmodule // qucfg_config

`default_nettype wire

// [qucfg_host.sv]
// Host processor model driving the configuration register strobe bus
`timescale 1ns/1ps
`default_nettype none

module qucfg_host (
  input  wire logic       sys_clk,
  input  wire logic [7:0] bus_rdata,
  output logic [7:0]      bus_addr,
  output logic            bus_wr,
  output logic            bus_rd,
  output logic [7:0]      bus_wdata
);
  initial begin
    bus_addr  = 8'h00;
    bus_wr    = 1'h0;
    bus_rd    = 1'h0;
    bus_wdata = 8'h00;
  end

  // One strobe per access, held over the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr  <= a;
    bus_wdata <= d;
    bus_wr    <= 1'h1;
    @(posedge sys_clk);
    bus_wr    <= 1'h0;
    // Released data must not look like the last value
    bus_wdata <= ~d;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_addr <= a;
    bus_rd   <= 1'h1;
    @(posedge sys_clk);
    bus_rd <= 1'h0;
    // Read data stand from the taking edge until the next read
    @(posedge sys_clk);
    d = bus_rdata;
  endtask
endmodule // qucfg_host

`default_nettype wire

// [qucfg_config_tb.sv]
// Self-checking bench for the configuration registers, timer and sleep control
`timescale 1ns/1ps
`default_nettype none

module qucfg_config_tb;
  // Arbitrary values
  localparam logic [7:0] ID_CODE  = 8'h94;
  localparam logic [7:0] REV_CODE = 8'h03;
  logic        sys_clk, reset_n, bus_wr, bus_rd, external_timer_clock_pin;
  logic        osc_stop, chan_ready, broadcast_write, irq_o, irq_oe;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata, d, v;
  logic [3:0]  chan_int_pending, chan_wake_event, sample_8x, chan_soft_reset, chan_asleep, rst_seen;
  logic [11:0] chan_src_code;
  int          seed, fails, check_count, cyc, k, t1, t2, rst_cycles;

  qucfg_config #(.PART_ID(ID_CODE), .REVISION(REV_CODE)) uut (
    .sys_clk(sys_clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .external_timer_clock_pin(external_timer_clock_pin),
    .chan_int_pending(chan_int_pending), .chan_src_code(chan_src_code), .chan_wake_event(chan_wake_event),
    .sample_8x(sample_8x), .chan_soft_reset(chan_soft_reset), .chan_asleep(chan_asleep), .osc_stop(osc_stop),
    .chan_ready(chan_ready), .broadcast_write(broadcast_write), .irq_o(irq_o), .irq_oe(irq_oe));

  qucfg_host host (.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata));

  initial begin
    sys_clk = 1'h0;
    forever #20 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  // Reset pulses are short, so a monitor catches every cycle of them
  always @(negedge sys_clk) begin
    if (chan_soft_reset !== 4'h0) begin
      rst_seen |= chan_soft_reset;
      rst_cycles++;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("Counts: checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wait_irq(input int limit, output int t);
    k = 0;
    @(negedge sys_clk);
    while (irq_oe !== 1'h1 && k < limit) begin
      @(negedge sys_clk);
      k++;
    end
    t = cyc;
    @(posedge sys_clk);
  endtask

  // Whole map plus one unmapped place, against reset contents
  task automatic read_all;
    for (int a = 8'h80; a <= 8'h8F; a++) begin
      host.rd(8'(a), d);
      chk(d, (a == 8'h8C) ? REV_CODE : (a == 8'h8D) ? ID_CODE : 8'h00);
    end
  endtask

  task automatic start_timer(input logic [7:0] ctl, input logic [7:0] n);
    host.wr(8'h84, 8'h00);
    host.wr(8'h86, n);
    host.wr(8'h87, 8'h00);
    host.wr(8'h84, ctl);
    // Stale time-out from an earlier run must not count as this one
    host.rd(8'h84, d);
    chk(d, ctl);
  endtask

  initial begin
    #(40 * 8000);
    fails++;
    print_verdict();
  end

  initial begin
    seed = 32'h0439e825;
    {fails, check_count, cyc, rst_cycles, rst_seen} = '0;
    {reset_n, external_timer_clock_pin, chan_int_pending, chan_wake_event, chan_src_code} = '0;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'h1;
    @(posedge sys_clk);
    chk({sample_8x, chan_asleep, osc_stop, chan_ready, broadcast_write}, 11'h2);
    read_all();
    host.wr(8'h84, 8'hF0);
    host.wr(8'h85, 8'hFF);
    host.wr(8'h89, 8'hFF);
    host.wr(8'h8C, 8'hFF);
    host.wr(8'h8D, 8'hFF);
    host.wr(8'h90, 8'hFF);
    read_all();
    $display("Test reset and reserved done");
    for (int i = 0; i < 16; i++) begin
      v = 8'($random(seed));
      chan_src_code <= {v[3:0], ~v};
      host.wr(8'h88, v);
      chk(sample_8x, v[3:0]);
      host.wr(8'h86, v);
      host.wr(8'h87, ~v);
      host.rd(8'h86, d);
      chk(d, v);
      host.rd(8'h87, d);
      chk(d, 8'(~v));
      host.wr(8'h8E, v);
      chk(broadcast_write, v[0]);
      host.rd(8'h81, d);
      chk(d, 8'(~v));
      host.rd(8'h82, d);
      chk(d, {4'h0, v[3:0]});
    end
    $display("Test random registers done");
    host.wr(8'h8A, 8'h09);
    cyc_wait(2);
    chk(rst_seen, 4'h9);
    chk(rst_cycles, 1);
    host.rd(8'h8A, d);
    chk(d, 8'h00);
    $display("Test soft reset done");
    start_timer(8'h03, 8'd20);
    wait_irq(60, t1);
    chk(irq_oe, 1'h1);
    host.rd(8'h81, d);
    chk(d, {chan_src_code[7:3], 3'h7});
    host.rd(8'h84, d);
    chk(d, 8'h03);
    wait_irq(60, t2);
    chk(t2 - t1, 20);
    start_timer(8'h07, 8'd8);
    wait_irq(40, t1);
    chk(irq_oe, 1'h1);
    host.rd(8'h84, d);
    chk(d, 8'h07);
    cyc_wait(40);
    chk(irq_oe, 1'h0);
    $display("Test internal timer done");
    // Single-shot has left the counter idle, so this start loads the preset afresh
    start_timer(8'h0B, 8'd3);
    cyc_wait(10);
    chk(irq_oe, 1'h0);
    repeat (3) begin
      external_timer_clock_pin <= 1'h1;
      cyc_wait(2);
      external_timer_clock_pin <= 1'h0;
      cyc_wait(2);
    end
    wait_irq(8, t1);
    chk(irq_oe, 1'h1);
    chk(irq_o, 1'h0);
    host.wr(8'h84, 8'h00);
    host.rd(8'h84, d);
    chk(d, 8'h00);
    $display("Test external timer done");
    start_timer(8'h02, 8'd5);
    cyc_wait(20);
    chk(irq_oe, 1'h0);
    host.rd(8'h81, d);
    chk(d, chan_src_code[7:0]);
    $display("Test masked timer done");
    chan_int_pending <= 4'h2;
    host.wr(8'h8B, 8'h0F);
    cyc_wait(3);
    chk({chan_asleep, osc_stop}, 5'h1A);
    chan_int_pending <= 4'h0;
    cyc_wait(3);
    chk({chan_asleep, osc_stop, irq_oe}, 6'h3E);
    chan_wake_event <= 4'h4;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({chan_asleep, osc_stop, chan_ready, irq_oe}, 7'h1);
    k = 0;
    while (chan_ready !== 1'h1 && k < 60) begin
      @(posedge sys_clk);
      k++;
      @(negedge sys_clk);
    end
    chk(k, 32);
    @(posedge sys_clk);
    host.wr(8'h8B, 8'h00);
    chan_wake_event <= 4'h0;
    host.rd(8'h80, d);
    chk(d, 8'h00);
    chk(irq_oe, 1'h0);
    chan_wake_event <= 4'h1;
    cyc_wait(2);
    chk({chan_ready, irq_oe}, 2'h2);
    chan_wake_event <= 4'h0;
    $display("Test sleep and wake done");
    print_verdict();
  end
endmodule // qucfg_config_tb

`default_nettype wire
